//--- design/tcd_channel.sv
// One down counter channel with its six modes, reset code and read latch.
// Assumes gate is already synchronised and commands arrive as one-cycle strobes.
//
// The implementer's own choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/10ps
module tcd_channel
    import tcd_pkg::*;
(
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Command.
    input  wire logic        load_i,
    input  wire logic [2:0]  code_i,
    input  wire logic [15:0] count_i,
    input  wire logic        bcd_i,
    input  wire logic        level_i,
    // Counter pins and state.
    input  wire logic        gate_i,
    output logic             out_o,
    output logic [15:0]      value_o,
    output logic [15:0]      latched_o,
    output logic [2:0]       mode_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [15:0] cnt, next_cnt, reload, next_reload, latched, next_latched;
    logic [2:0]  mode, next_mode;
    logic        outr, next_outr, bcd, next_bcd, run, next_run, gate_q, next_gate_q;
    logic        rise;
    logic [15:0] dec, dec2;

    assign rise = gate_i & ~gate_q;
    assign dec  = tcd_dec(cnt, bcd);
    assign dec2 = tcd_dec(dec, bcd);

    always_comb begin
        next_cnt     = cnt;
        next_reload  = reload;
        next_latched = latched;
        next_mode    = mode;
        next_outr    = outr;
        next_bcd     = bcd;
        next_run     = run;
        next_gate_q  = gate_i;
        if (load_i && code_i == TCD_CODE_READ) begin
            next_latched = cnt;
        end else if (load_i && code_i == TCD_CODE_RESET) begin
            next_cnt  = TCD_ZERO;
            next_run  = 1'b0;
            next_outr = level_i;
            next_mode = code_i;
        end else if (load_i) begin
            next_mode   = code_i;
            next_bcd    = bcd_i;
            next_reload = count_i;
            next_cnt    = count_i;
            next_run    = (code_i != 3'(gated_single_pulse_mode)) && (code_i != 3'(edge_gated_strobe_mode));
            next_outr   = (code_i != 3'(low_until_zero_mode));
        end else begin
            case (tcd_op_e'(mode))
                low_until_zero_mode: begin
                    if (run && gate_i) begin
                        next_cnt = dec;
                        if (dec == TCD_ZERO) begin
                            next_outr = 1'b1;
                            next_run  = 1'b0;
                        end
                    end
                end
                gated_single_pulse_mode: begin
                    if (rise) begin
                        next_cnt  = reload;
                        next_run  = 1'b1;
                        next_outr = 1'b0;
                    end else if (run) begin
                        next_cnt = dec;
                        if (dec == TCD_ZERO) begin
                            next_outr = 1'b1;
                            next_run  = 1'b0;
                        end
                    end
                end
                periodic_low_pulse_mode: begin
                    if (gate_i) begin
                        next_cnt  = (cnt == TCD_ONE) ? reload : dec;
                        next_outr = (dec != TCD_ONE);
                    end
                end
                half_duty_wave_mode: begin
                    // Counts by two per phase; an odd count gives the high phase the extra clock.
                    if (gate_i) begin
                        next_cnt = dec2;
                        if (reload[0] ? (outr ? (dec == TCD_ZERO) : (dec2 == TCD_ONE)) : (dec2 == TCD_ZERO)) begin
                            next_cnt  = reload;
                            next_outr = ~outr;
                        end
                    end
                end
                level_gated_strobe_mode, edge_gated_strobe_mode: begin
                    next_outr = 1'b1;
                    if (mode == 3'(edge_gated_strobe_mode) && rise) begin
                        next_cnt = reload;
                        next_run = 1'b1;
                    end else if (run && (gate_i || mode == 3'(edge_gated_strobe_mode))) begin
                        next_cnt = dec;
                        if (dec == TCD_ZERO) begin
                            next_outr = 1'b0;
                            next_run  = 1'b0;
                        end
                    end
                end
                default: begin
                    next_cnt = cnt;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt     <= TCD_ZERO;
            reload  <= TCD_ZERO;
            latched <= TCD_ZERO;
            mode    <= TCD_CODE_RESET;
            outr    <= 1'b1;
            bcd     <= 1'b0;
            run     <= 1'b0;
            gate_q  <= 1'b0;
        end else begin
            cnt     <= next_cnt;
            reload  <= next_reload;
            latched <= next_latched;
            mode    <= next_mode;
            outr    <= next_outr;
            bcd     <= next_bcd;
            run     <= next_run;
            gate_q  <= next_gate_q;
        end
    end

    assign out_o     = outr;
    assign value_o   = cnt;
    assign latched_o = latched;
    assign mode_o    = mode;

    ////////////////////////////////////////////////////////////////////////
    property p_reset_level;
        @(posedge clk_i) disable iff (rst_i)
        (load_i && code_i == TCD_CODE_RESET) |=> (out_o == $past(level_i) && value_o == TCD_ZERO);
    endproperty
    a_reset_level: assert property (p_reset_level) else $error("Reset code did not force output.");

    property p_read_latch;
        @(posedge clk_i) disable iff (rst_i)
        (load_i && code_i == TCD_CODE_READ) |=> (latched_o == $past(value_o));
    endproperty
    a_read_latch: assert property (p_read_latch) else $error("Read code did not latch count.");

    property p_mode0_low;
        @(posedge clk_i) disable iff (rst_i)
        (load_i && code_i == 3'(low_until_zero_mode) && count_i > TCD_ONE) |=> !out_o;
    endproperty
    a_mode0_low: assert property (p_mode0_low) else $error("Mode 0 output not low after set.");

    property p_mode15;
        @(posedge clk_i) disable iff (rst_i)
        load_i && code_i < 3'h6 |=> mode_o == $past(code_i);
    endproperty
    a_mode15: assert property (p_mode15) else $error("Mode not taken on load.");

    sequence s_m2_low;
        mode_o == 3'(periodic_low_pulse_mode) && !out_o && !load_i && gate_i;
    endsequence
    property p_m2_pulse;
        @(posedge clk_i) disable iff (rst_i)
        s_m2_low |=> out_o || load_i;
    endproperty
    a_m2_pulse: assert property (p_m2_pulse) else $error("Mode 2 low pulse too long.");

    property p_m4_pulse;
        @(posedge clk_i) disable iff (rst_i)
        (mode_o == 3'(level_gated_strobe_mode) && !out_o && !load_i) |=> out_o || load_i;
    endproperty
    a_m4_pulse: assert property (p_m4_pulse) else $error("Mode 4 strobe too long.");

    property p_m5_start;
        @(posedge clk_i) disable iff (rst_i)
        (mode_o == 3'(edge_gated_strobe_mode) && rise && !load_i) |=> value_o == $past(reload);
    endproperty
    a_m5_start: assert property (p_m5_start) else $error("Mode 5 did not start on gate edge.");

    property p_bcd_digits;
        @(posedge clk_i) disable iff (rst_i)
        (bcd && !load_i && $past(value_o) != TCD_ZERO && mode_o != TCD_CODE_RESET)
            |-> (value_o[3:0] <= 4'h9 && value_o[7:4] <= 4'h9);
    endproperty
    a_bcd_digits: assert property (p_bcd_digits) else $error("BCD digit out of range.");

endmodule : tcd_channel

//--- design/tcd_top.sv
// Top of the three channel down counter with its Wishbone register slave.
// Assumes a classic Wishbone master on clk_i and gate pins from outside.
`timescale 1ns/10ps
module tcd_top
    import tcd_pkg::*;
(
    // Clock and reset.
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    // Wishbone slave.
    input  wire logic                    cyc_i,
    input  wire logic                    stb_i,
    input  wire logic                    we_i,
    input  wire logic [TCD_AW-1:0]       adr_i,
    input  wire logic [3:0]              sel_i,
    input  wire logic [31:0]             dat_i,
    output logic      [31:0]             dat_o,
    output logic                         ack_o,
    // Counter pins.
    input  wire logic [TCD_CHANNELS-1:0] gate_i,
    output logic      [TCD_CHANNELS-1:0] out_o
);

    ////////////////////////////////////////////////////////////////////////
    logic [TCD_CHANNELS-1:0] g1, g2, load;
    logic [15:0] latched [TCD_CHANNELS];
    logic [2:0]  mode    [TCD_CHANNELS];
    logic [1:0]  rd_chan, next_rd_chan;
    logic [31:0] next_dat;
    logic        next_ack, req, wr_cmd;
    logic [1:0]  chan;

    assign req    = cyc_i & stb_i & ~ack_o;
    assign chan   = dat_i[TCD_CHAN_LSB +: 2];
    assign wr_cmd = req & we_i & (adr_i == TCD_ADDR_CMD) & (&sel_i[2:0]);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            g1 <= '0;
            g2 <= '0;
        end else begin
            g1 <= gate_i;
            g2 <= g1;
        end
    end

    for (genvar i = 0; i < TCD_CHANNELS; i++) begin : g_ch
        assign load[i] = wr_cmd && chan == 2'(i);
        tcd_channel u_ch (
            .clk_i     (clk_i),
            .rst_i     (rst_i),
            .load_i    (load[i]),
            .code_i    (dat_i[TCD_CODE_LSB +: 3]),
            .count_i   (dat_i[TCD_CNT_LSB +: 16]),
            .bcd_i     (dat_i[TCD_BCD_BIT]),
            .level_i   (dat_i[TCD_LVL_BIT]),
            .gate_i    (g2[i]),
            .out_o     (out_o[i]),
            .value_o   (),
            .latched_o (latched[i]),
            .mode_o    (mode[i])
        );
    end

    always_comb begin
        next_ack     = req;
        next_rd_chan = rd_chan;
        next_dat     = 32'h0000_0000;
        if (wr_cmd && dat_i[TCD_CODE_LSB +: 3] == TCD_CODE_READ && chan < 2'(TCD_CHANNELS)) begin
            next_rd_chan = chan;
        end
        if (req && !we_i) begin
            if (adr_i == TCD_ADDR_READ) begin
                next_dat = {16'h0000, latched[rd_chan]};
            end else if (adr_i == TCD_ADDR_STAT) begin
                next_dat = {16'h0000, 1'b0, mode[2], 1'b0, mode[1], 1'b0, mode[0], 1'b0, out_o};
            end else begin
                next_dat = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o   <= 1'b0;
            dat_o   <= 32'h0000_0000;
            rd_chan <= 2'b00;
        end else begin
            ack_o   <= next_ack;
            dat_o   <= next_dat;
            rd_chan <= next_rd_chan;
        end
    end

endmodule : tcd_top

//--- inc/tcd_pkg.sv
// Constants, register map and types for the three channel down counter.
// Assumes a classic Wishbone slave with 32-bit data and a single 50 MHz clock.
//
// Summary of operation
// - Three counters, selected by index 0 to 2.
// - Binary format counts sixteen bits, 0 to 65535.
// - Decimal format counts four BCD decades, 0 to 9999.
// - Code 7 resets counter, forces chosen output level.
// - Code 6 latches counter value for host read.
// - Mode 0: low on set, high at zero.
// - Mode 1: low after gate edge, high at zero.
// - Mode 2: one clock low pulse every count.
// - Mode 3: high half count, low other half.
// - Mode 4: gated count, one low pulse at zero.
// - Mode 5: like mode 4, started by gate edge.
// - Loaded zero means full count, 65536 or 10000.
package tcd_pkg;

    localparam int          TCD_CHANNELS   = 3;
    localparam int          TCD_AW         = 4;
    localparam logic [3:0]  TCD_ADDR_CMD   = 4'h0;
    localparam logic [3:0]  TCD_ADDR_READ  = 4'h4;
    localparam logic [3:0]  TCD_ADDR_STAT  = 4'h8;
    localparam int          TCD_CNT_LSB    = 0;
    localparam int          TCD_CODE_LSB   = 16;
    localparam int          TCD_CHAN_LSB   = 20;
    localparam int          TCD_BCD_BIT    = 24;
    localparam int          TCD_LVL_BIT    = 25;
    localparam logic [2:0]  TCD_CODE_READ  = 3'h6;
    localparam logic [2:0]  TCD_CODE_RESET = 3'h7;
    localparam logic [15:0] TCD_BIN_MAX    = 16'hFFFF;
    localparam logic [15:0] TCD_BCD_MAX    = 16'h9999;
    localparam logic [15:0] TCD_ONE        = 16'h0001;
    localparam logic [15:0] TCD_ZERO       = 16'h0000;

    typedef enum logic [2:0] {
        low_until_zero_mode,
        gated_single_pulse_mode,
        periodic_low_pulse_mode,
        half_duty_wave_mode,
        level_gated_strobe_mode,
        edge_gated_strobe_mode,
        read_code,
        reset_code
    } tcd_op_e;

    // Decrements a count by one in binary or four-decade BCD.
    function automatic logic [15:0] tcd_dec(input logic [15:0] v, input logic bcd);
        logic [15:0] r;
        r = v - TCD_ONE;
        if (bcd) begin
            r = v;
            for (int d = 0; d < 4; d++) begin
                if (r[d*4 +: 4] != 4'h0) begin
                    r[d*4 +: 4] = r[d*4 +: 4] - 4'h1;
                    break;
                end
                r[d*4 +: 4] = 4'h9;
            end
        end
        return r;
    endfunction : tcd_dec

endpackage : tcd_pkg

//--- tb/tcd_host_model.sv
// Host model: a classic Wishbone master that programs and reads the counters.
// Assumes the slave answers on clk_i with a one-cycle ack, and no request before reset ends.
`timescale 1ns/10ps
module tcd_host_model
    import tcd_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone master.
    output logic                   cyc_o,
    output logic                   stb_o,
    output logic                   we_o,
    output logic [TCD_AW-1:0]      adr_o,
    output logic [3:0]             sel_o,
    output logic [31:0]            dat_o,
    input  wire logic [31:0]       dat_i,
    input  wire logic              ack_i
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 4'hF;
        sel_o = 4'h0;
        dat_o = 32'h5A5A_5A5A;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One transfer; the request stands until the edge where ack is high.
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= w;
        adr_o <= a;
        sel_o <= 4'hF;
        dat_o <= wd;
        do @(posedge clk_i); while (ack_i !== 1'b1);
        rd = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        adr_o <= ~a;
        dat_o <= ~wd;
    endtask : xfer
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        xfer(1'b0, a, 32'h0000_0000, d);
    endtask : rd
    // Counts are kept to the legal range of the chosen code and format.
    task automatic cmd(input logic [1:0] ch, input logic [2:0] code, input logic [15:0] cnt,
                       input logic bcd, input logic lvl);
        logic [31:0] d;
        logic [15:0] c;
        c = cnt;
        if ((code == 3'h2 || code == 3'h3) && c < 16'h0002) c = 16'h0002;
        if (bcd && c > TCD_BCD_MAX) c = TCD_BCD_MAX;
        xfer(1'b1, TCD_ADDR_CMD, {6'h00, lvl, bcd, 2'h0, ch, 1'h0, code, c}, d);
    endtask : cmd
endmodule : tcd_host_model

//--- tb/tcd_top_tb_top.sv
// Testbench top for the three channel down counter.
// Assumes the host model drives the Wishbone side and the bench drives the gates.
`timescale 1ns/10ps
module tcd_top_tb_top
    import tcd_pkg::*;
();
    typedef struct packed {
        logic [1:0] ch;
        logic [2:0] code;
        logic       lvl;
        logic [2:0] out;
        logic [2:0] msk;
        logic [1:0] mch;
        logic [2:0] mode;
    } tcd_row_s;
    logic                    clk_i;
    logic                    rst_i;
    logic                    cyc;
    logic                    stb;
    logic                    we;
    logic [TCD_AW-1:0]       adr;
    logic [3:0]              sel;
    logic [31:0]             wdat;
    logic [31:0]             rdat;
    logic                    ack;
    logic [TCD_CHANNELS-1:0] gate;
    logic [TCD_CHANNELS-1:0] out;
    logic [31:0]             d;
    int                      n;
    int                      fail_count = 0;
    int                      checks_done = 0;
    tcd_row_s                rows [11] = '{
        '{2'h0, 3'h7, 1'h0, 3'h6, 3'h7, 2'h0, 3'h7}, '{2'h1, 3'h7, 1'h0, 3'h4, 3'h7, 2'h1, 3'h7},
        '{2'h2, 3'h7, 1'h0, 3'h0, 3'h7, 2'h2, 3'h7}, '{2'h3, 3'h7, 1'h1, 3'h0, 3'h7, 2'h2, 3'h7},
        '{2'h0, 3'h7, 1'h1, 3'h1, 3'h7, 2'h0, 3'h7}, '{2'h1, 3'h4, 1'h0, 3'h3, 3'h7, 2'h1, 3'h4},
        '{2'h2, 3'h5, 1'h0, 3'h7, 3'h7, 2'h2, 3'h5}, '{2'h0, 3'h0, 1'h0, 3'h6, 3'h7, 2'h0, 3'h0},
        '{2'h1, 3'h1, 1'h0, 3'h6, 3'h7, 2'h1, 3'h1}, '{2'h2, 3'h2, 1'h0, 3'h6, 3'h7, 2'h2, 3'h2},
        '{2'h0, 3'h3, 1'h0, 3'h7, 3'h7, 2'h0, 3'h3}};
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    tcd_host_model h (.clk_i(clk_i), .rst_i(rst_i), .cyc_o(cyc), .stb_o(stb), .we_o(we), .adr_o(adr),
                      .sel_o(sel), .dat_o(wdat), .dat_i(rdat), .ack_i(ack));
    tcd_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
                 .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .gate_i(gate), .out_o(out));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic rng(input string nm, input int g, input int lo, input int hi);
        checks_done++;
        if (g < lo || g > hi) begin
            fail_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
        end
    endtask : rng
    task automatic set_gate(input int ch, input logic v);
        @(posedge clk_i);
        gate[ch] <= v;
    endtask : set_gate
    task automatic wait_out(input int ch, input logic v, input int lim, output int k);
        k = 0;
        while (out[ch] !== v && k < lim) begin
            @(negedge clk_i);
            k++;
        end
    endtask : wait_out
    task automatic read_cnt(input logic [1:0] ch, input int gated);
        if (gated > 0) begin
            set_gate(ch, 1'b1);
            repeat (gated) @(posedge clk_i);
            gate[ch] <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        h.cmd(ch, TCD_CODE_READ, TCD_ZERO, 1'b0, 1'b0);
        h.rd(TCD_ADDR_READ, d);
    endtask : read_cnt
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk_i);
        fail_count++;
        print_verdict();
    end
    initial begin
        rst_i = 1'b1;
        gate  = 3'b000;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("reset out", 16'h0007, 16'(out));
        chk("reset ack", 16'h0000, 16'(ack));
        h.rd(TCD_ADDR_STAT, d);
        chk("reset stat", 16'h7777, d[15:0]);
        for (int i = 0; i < 11; i++) begin
            h.cmd(rows[i].ch, rows[i].code, 16'h0100, 1'b0, rows[i].lvl);
            h.rd(TCD_ADDR_STAT, d);
            chk("row out", 16'(rows[i].out & rows[i].msk), 16'(d[2:0] & rows[i].msk));
            chk("row mode", 16'(rows[i].mode), 16'(d[4*rows[i].mch+4 +: 3]));
        end
        h.cmd(0, 3'h0, 16'h1234, 1'b0, 1'b0);
        read_cnt(0, 0);
        chk("held count", 16'h1234, d[15:0]);
        read_cnt(0, 20);
        rng("gated count", int'(16'h1234) - int'(d[15:0]), 17, 23);
        h.cmd(2, 3'h0, TCD_ZERO, 1'b1, 1'b0);
        read_cnt(2, 12);
        chk("bcd zero", 16'h0099, 16'(d[15:8]));
        chk("bcd tens", 16'h0008, 16'(d[7:4]));
        chk("bcd units", 16'h0008, 16'(d[3:0]));
        h.cmd(2, 3'h0, TCD_ZERO, 1'b0, 1'b0);
        read_cnt(2, 12);
        chk("bin zero", 16'h00FF, 16'(d[15:8]));
        h.cmd(1, 3'h0, 16'd40, 1'b0, 1'b0);
        set_gate(1, 1'b1);
        wait_out(1, 1'b1, 80, n);
        rng("mode0 end", n, 38, 46);
        set_gate(0, 1'b1);
        h.cmd(0, 3'h2, 16'd5, 1'b0, 1'b0);
        wait_out(0, 1'b0, 30, n);
        for (int k = 0; k < 2; k++) begin
            wait_out(0, 1'b1, 10, n);
            rng("rate low", n, 1, 1);
            wait_out(0, 1'b0, 20, n);
            rng("rate high", n, 4, 4);
        end
        h.cmd(1, 3'h3, 16'd6, 1'b0, 1'b0);
        wait_out(1, 1'b0, 30, n);
        wait_out(1, 1'b1, 20, n);
        rng("wave low", n, 3, 3);
        wait_out(1, 1'b0, 20, n);
        rng("wave high", n, 3, 3);
        h.cmd(1, 3'h3, 16'd5, 1'b0, 1'b0);
        wait_out(1, 1'b0, 30, n);
        wait_out(1, 1'b1, 20, n);
        rng("odd wave low", n, 2, 2);
        wait_out(1, 1'b0, 20, n);
        rng("odd wave high", n, 3, 3);
        set_gate(2, 1'b1);
        h.cmd(2, 3'h4, 16'd8, 1'b0, 1'b0);
        wait_out(2, 1'b0, 30, n);
        rng("strobe wait", n, 7, 12);
        wait_out(2, 1'b1, 5, n);
        rng("strobe low", n, 1, 1);
        wait_out(2, 1'b0, 30, n);
        rng("strobe once", n, 30, 30);
        set_gate(2, 1'b0);
        h.cmd(2, 3'h5, 16'd8, 1'b0, 1'b0);
        wait_out(2, 1'b0, 30, n);
        rng("edge idle", n, 30, 30);
        set_gate(2, 1'b1);
        wait_out(2, 1'b0, 30, n);
        rng("edge wait", n, 7, 13);
        wait_out(2, 1'b1, 5, n);
        rng("edge low", n, 1, 1);
        set_gate(0, 1'b0);
        h.cmd(0, 3'h1, 16'd6, 1'b0, 1'b0);
        set_gate(0, 1'b1);
        wait_out(0, 1'b0, 10, n);
        rng("shot start", n, 1, 5);
        wait_out(0, 1'b1, 20, n);
        rng("shot low", n, 5, 8);
        h.cmd(1, 3'h0, 16'd100, 1'b0, 1'b0);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        chk("mid reset out", 16'h0007, 16'(out));
        h.rd(TCD_ADDR_STAT, d);
        chk("mid reset stat", 16'h7777, d[15:0]);
        h.rd(TCD_ADDR_READ, d);
        chk("mid reset read", 16'h0000, d[15:0]);
        h.rd(4'hC, d);
        chk("unmapped", 16'h0000, d[15:0] | d[31:16]);
        print_verdict();
    end
endmodule : tcd_top_tb_top
